// ===== rtl/ifrtx_ctrl.sv
// In-frame response transmit control with its response byte FIFO
// Functional notes
// [R01] Active normalization bit precedes the response
// [R02] One shared normalization bit for all responders
// [R03] Single request: after EOD send bit, byte
// [R04] Single request clears on success, EOD, error
// [R05] Single request after received EOD is ignored
// [R06] Single loss: retry byte without normalization bit
// [R07] Single loss late: no extra one bits
// [R08] CRC mode: bit, bytes, CRC, then EOD
// [R09] Holding empty raised when byte enters shifter
// [R10] Host refills per empty flag, then commands EOD
// [R11] CRC request clears on done, error, underrun
// [R12] One byte plus CRC: no further empty flag
// [R13] CRC request after received EOD is ignored
// [R14] CRC loss: flag, stop, clear; late adds ones
// [R15] No-CRC mode: last written byte, then EOD
// [R16] No-CRC request clears on done, error, underrun
// [R17] No-CRC request after received EOD ignored
// [R18] No-CRC loss: clear, no retry; late ones
// [R19] Priority encode request bits; readback as written
// [R20] Format select sets normalization bit polarity
`timescale 1ns/1ps
`default_nettype none

module ifrtx_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);
  localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;
  localparam logic [AW:0] CNT_FULL = (AW+1)'(D);
  localparam logic [AW-1:0] PTR_LAST = AW'(D - 1);

  logic [W-1:0]  mem_reg [D];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0]   cnt_reg;
  logic          push;
  logic          pop;

  assign in_ready_o  = (cnt_reg != CNT_FULL);
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign push = ce_i && in_valid_i && in_ready_o;
  assign pop  = ce_i && out_ready_i && out_valid_o;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule : ifrtx_fifo

module ifrtx_ctrl #(
  parameter int unsigned FIFO_DEPTH = 8
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                ce_i,
  input  wire logic                req_wr_i,
  input  wire logic [2:0]          req_bits_i,
  output logic [2:0]               req_bits_o,
  input  wire logic                eod_cmd_wr_i,
  output logic                     end_of_data_command_o,
  input  wire logic                norm_bit_format_sel_i,
  input  wire logic                data_valid_i,
  input  wire logic [7:0]          data_i,
  output logic                     data_ready_o,
  output logic                     tx_holding_empty_o,
  input  wire logic                eod_rx_i,
  input  wire logic                eof_rx_i,
  input  wire logic                rx_byte_i,
  input  wire logic                bus_error_i,
  output ifrtx_pkg::ifrtx_sym_t    sym_o,
  output logic                     sym_valid_o,
  input  wire logic                sym_done_i,
  input  wire logic                arb_lost_i,
  output logic                     arb_lost_o,
  output logic                     underrun_o,
  output logic                     busy_o
);
  ifrtx_pkg::ifrtx_state_t st_reg;
  logic [2:0] req_reg;
  logic       eod_cmd_reg;
  logic       eod_seen_reg;
  logic       hold_empty_reg;
  logic       arb_lost_reg;
  logic       underrun_reg;
  logic [7:0] shift_reg;
  logic [7:0] hold_reg;
  logic [7:0] crc_reg;
  logic [2:0] bit_cnt_reg;
  logic       crc_phase_reg;
  logic       fo_valid;
  logic [7:0] fo_data;
  logic       eff_sgl;
  logic       eff_crc;
  logic       eff_noc;
  logic       multi;
  logic       start;
  logic       load_first;
  logic       nb_done;
  logic       bit_ok;
  logic       lost;
  logic       byte_end;
  logic       load_next;
  logic       to_crc;
  logic       to_eod;
  logic       underrun;
  logic       eod_done;
  logic       extra_done;
  logic       abort;
  logic       req_take;
  logic       req_clr;
  logic       crc_fb;

  ifrtx_fifo #(.W(ifrtx_pkg::BYTE_W), .D(FIFO_DEPTH)) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .in_valid_i  (data_valid_i),
    .in_data_i   (data_i),
    .in_ready_o  (data_ready_o),
    .out_valid_o (fo_valid),
    .out_data_o  (fo_data),
    .out_ready_i (load_first || load_next)
  );

  // Internal view keeps only the highest-priority request bit
  assign eff_sgl = req_reg[ifrtx_pkg::REQ_SGL]; // R19
  assign eff_crc = !eff_sgl && req_reg[ifrtx_pkg::REQ_CRC]; // R19
  assign eff_noc = !eff_sgl && !req_reg[ifrtx_pkg::REQ_CRC] && req_reg[ifrtx_pkg::REQ_NOC];
  assign multi   = eff_crc || eff_noc;

  always_comb begin
    start      = ce_i && (st_reg == ifrtx_pkg::ST_WAIT) && eod_rx_i;
    load_first = start && fo_valid; // R03
    nb_done    = ce_i && (st_reg == ifrtx_pkg::ST_NB) && sym_done_i;
    bit_ok     = ce_i && (st_reg == ifrtx_pkg::ST_DATA) && sym_done_i && !arb_lost_i;
    lost       = ce_i && (st_reg == ifrtx_pkg::ST_DATA) && sym_done_i && arb_lost_i;
    byte_end   = bit_ok && (bit_cnt_reg == ifrtx_pkg::BIT_LAST);
    load_next  = byte_end && multi && !crc_phase_reg && fo_valid;
    to_crc     = byte_end && eff_crc && !crc_phase_reg && !fo_valid && eod_cmd_reg; // R08
    to_eod     = byte_end && (crc_phase_reg || (eff_noc && !fo_valid && eod_cmd_reg)); // R15
    underrun   = (byte_end && multi && !crc_phase_reg && !fo_valid && !eod_cmd_reg)
                 || (start && !fo_valid);
    eod_done   = ce_i && (st_reg == ifrtx_pkg::ST_EOD) && sym_done_i;
    extra_done = ce_i && (st_reg == ifrtx_pkg::ST_EXTRA) && sym_done_i
                 && (bit_cnt_reg == ifrtx_pkg::EXTRA_END);
    abort      = ce_i && (st_reg != ifrtx_pkg::ST_IDLE)
                 && (bus_error_i || (eff_sgl && eod_cmd_reg)); // R04
    // Requests landing after a received EOD are dropped until frame end
    req_take   = ce_i && req_wr_i && !eod_seen_reg && !eod_rx_i; // R05 R13 R17
    req_clr    = (byte_end && eff_sgl) || eod_done || underrun
                 || (lost && multi) || abort; // R04 R11 R16
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      eod_seen_reg <= 1'b0;
    end else if (ce_i) begin
      if (eod_rx_i) begin
        eod_seen_reg <= 1'b1;
      end else if (eof_rx_i) begin
        eod_seen_reg <= 1'b0;
      end
    end
  end

  // Readback stays as written; a fresh write wins over a hardware clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_reg <= ifrtx_pkg::REQ_NONE;
    end else if (req_take) begin
      req_reg <= req_bits_i; // R19
    end else if (req_clr) begin
      req_reg <= ifrtx_pkg::REQ_NONE;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      eod_cmd_reg <= 1'b0;
    end else if (ce_i && eod_cmd_wr_i) begin
      eod_cmd_reg <= 1'b1;
    end else if (req_clr) begin
      eod_cmd_reg <= 1'b0;
    end
  end

  // Set only while no end of data is pending, so a one byte CRC reply flags its byte but never its CRC
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_empty_reg <= 1'b0;
    end else if ((load_first || load_next) && multi && !eod_cmd_reg) begin
      hold_empty_reg <= 1'b1; // R09 R12
    end else if (ce_i && (data_valid_i || eod_cmd_wr_i || req_clr)) begin
      hold_empty_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      arb_lost_reg <= 1'b0;
      underrun_reg <= 1'b0;
    end else begin
      if (lost && multi) begin
        arb_lost_reg <= 1'b1; // R14 R18
      end else if (req_take) begin
        arb_lost_reg <= 1'b0;
      end
      if (underrun) begin
        underrun_reg <= 1'b1;
      end else if (req_take) begin
        underrun_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= ifrtx_pkg::ST_IDLE;
    end else if (ce_i) begin
      if (abort) begin
        st_reg <= ifrtx_pkg::ST_IDLE;
      end else begin
        case (st_reg)
          ifrtx_pkg::ST_IDLE: begin
            if (req_reg != ifrtx_pkg::REQ_NONE) begin
              st_reg <= ifrtx_pkg::ST_WAIT;
            end
          end
          ifrtx_pkg::ST_WAIT: begin
            if (req_reg == ifrtx_pkg::REQ_NONE) begin
              st_reg <= ifrtx_pkg::ST_IDLE;
            end else if (load_first) begin
              st_reg <= ifrtx_pkg::ST_NB; // R01 R02
            end else if (start) begin
              st_reg <= ifrtx_pkg::ST_IDLE;
            end
          end
          ifrtx_pkg::ST_NB: begin
            if (nb_done) begin
              st_reg <= ifrtx_pkg::ST_DATA;
            end
          end
          ifrtx_pkg::ST_DATA: begin
            if (lost && eff_sgl) begin
              st_reg <= ifrtx_pkg::ST_RETRY; // R06 R07
            end else if (lost && bit_cnt_reg >= ifrtx_pkg::BIT_LATE) begin
              st_reg <= ifrtx_pkg::ST_EXTRA; // R14 R18
            end else if (lost) begin
              st_reg <= ifrtx_pkg::ST_IDLE;
            end else if (to_eod) begin
              st_reg <= ifrtx_pkg::ST_EOD;
            end else if (underrun) begin
              st_reg <= ifrtx_pkg::ST_EXTRA;
            end else if (byte_end && eff_sgl) begin
              st_reg <= ifrtx_pkg::ST_IDLE;
            end
          end
          ifrtx_pkg::ST_RETRY: begin
            if (rx_byte_i) begin
              st_reg <= ifrtx_pkg::ST_DATA; // R06
            end
          end
          ifrtx_pkg::ST_EXTRA: begin
            if (extra_done) begin
              st_reg <= ifrtx_pkg::ST_IDLE;
            end
          end
          ifrtx_pkg::ST_EOD: begin
            if (eod_done) begin
              st_reg <= ifrtx_pkg::ST_IDLE;
            end
          end
          default: begin
            st_reg <= ifrtx_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  assign crc_fb = crc_reg[7] ^ shift_reg[7];

  // Shifter, bit counter and CRC; MSB leaves first
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      shift_reg     <= '0;
      hold_reg      <= '0;
      crc_reg       <= ifrtx_pkg::CRC_INIT;
      bit_cnt_reg   <= ifrtx_pkg::CNT_ZERO;
      crc_phase_reg <= 1'b0;
    end else if (ce_i) begin
      if (load_first) begin
        shift_reg     <= fo_data;
        hold_reg      <= fo_data;
        crc_reg       <= ifrtx_pkg::CRC_INIT;
        bit_cnt_reg   <= ifrtx_pkg::CNT_ZERO;
        crc_phase_reg <= 1'b0;
      end else if (st_reg == ifrtx_pkg::ST_RETRY) begin
        shift_reg   <= hold_reg;
        bit_cnt_reg <= ifrtx_pkg::CNT_ZERO;
      end else if (lost || underrun) begin
        bit_cnt_reg <= ifrtx_pkg::CNT_ZERO;
      end else if (bit_ok) begin
        crc_reg     <= {crc_reg[6:0], 1'b0} ^ (crc_fb ? ifrtx_pkg::CRC_POLY : 8'h00);
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (load_next) begin
          shift_reg <= fo_data;
          hold_reg  <= fo_data;
        end else if (to_crc) begin
          shift_reg     <= ~({crc_reg[6:0], 1'b0} ^ (crc_fb ? ifrtx_pkg::CRC_POLY : 8'h00));
          crc_phase_reg <= 1'b1; // R08
        end else begin
          shift_reg <= {shift_reg[6:0], 1'b0};
        end
      end else if (ce_i && (st_reg == ifrtx_pkg::ST_EXTRA) && sym_done_i) begin
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
      end
    end
  end

  // Symbol word is decoded from registers plus the norm_bit_format_sel_i input, which sets the normalization bit value
  always_comb begin
    sym_o.kind  = ifrtx_pkg::SYM_NONE;
    sym_o.value = 1'b0;
    case (st_reg)
      ifrtx_pkg::ST_NB: begin
        sym_o.kind  = ifrtx_pkg::SYM_NB;
        sym_o.value = eff_crc ^ norm_bit_format_sel_i; // R20
      end
      ifrtx_pkg::ST_DATA: begin
        sym_o.kind  = ifrtx_pkg::SYM_BIT;
        sym_o.value = shift_reg[7];
      end
      ifrtx_pkg::ST_EXTRA: begin
        sym_o.kind  = ifrtx_pkg::SYM_BIT;
        sym_o.value = 1'b1;
      end
      ifrtx_pkg::ST_EOD: begin
        sym_o.kind  = ifrtx_pkg::SYM_EOD;
      end
      default: begin
        sym_o.kind  = ifrtx_pkg::SYM_NONE;
      end
    endcase
  end

  assign sym_valid_o           = (sym_o.kind != ifrtx_pkg::SYM_NONE);
  assign req_bits_o            = req_reg;
  assign end_of_data_command_o = eod_cmd_reg;
  assign tx_holding_empty_o    = hold_empty_reg;
  assign arb_lost_o            = arb_lost_reg;
  assign underrun_o            = underrun_reg;
  assign busy_o                = (st_reg != ifrtx_pkg::ST_IDLE);

  sequence s_nb_sent;
    (st_reg == ifrtx_pkg::ST_NB) && sym_done_i && ce_i;
  endsequence
  property p_nb_first;
    @(posedge clk_i) disable iff (rst_i) load_first && !abort |=> (st_reg == ifrtx_pkg::ST_NB);
  endproperty
  a_nb_first: assert property (p_nb_first) else $error("no normalization bit after EOD"); // R01
  property p_nb_then_data;
    @(posedge clk_i) disable iff (rst_i) s_nb_sent ##0 !abort |=> sym_o.kind == ifrtx_pkg::SYM_BIT;
  endproperty
  a_nb_then_data: assert property (p_nb_then_data) else $error("data missing after bit"); // R03
  property p_nb_pol;
    @(posedge clk_i) disable iff (rst_i)
      (st_reg == ifrtx_pkg::ST_NB)
      |-> sym_o.value == ((req_reg[ifrtx_pkg::REQ_CRC] && !req_reg[ifrtx_pkg::REQ_SGL])
                          ? !norm_bit_format_sel_i : norm_bit_format_sel_i);
  endproperty
  a_nb_pol: assert property (p_nb_pol) else $error("normalization polarity wrong"); // R20
  property p_late_req;
    @(posedge clk_i) disable iff (rst_i)
      eod_seen_reg && req_wr_i && ce_i && !req_reg[0] |=> !req_reg[0];
  endproperty
  a_late_req: assert property (p_late_req) else $error("late request was taken"); // R17
  property p_sgl_retry;
    @(posedge clk_i) disable iff (rst_i)
      lost && eff_sgl && !abort |=> (st_reg == ifrtx_pkg::ST_RETRY) && !sym_valid_o;
  endproperty
  a_sgl_retry: assert property (p_sgl_retry) else $error("single loss did not wait"); // R06 R07
  property p_multi_late;
    @(posedge clk_i) disable iff (rst_i)
      lost && multi && !abort && bit_cnt_reg >= ifrtx_pkg::BIT_LATE
      |=> (st_reg == ifrtx_pkg::ST_EXTRA) && arb_lost_o && (req_reg == ifrtx_pkg::REQ_NONE);
  endproperty
  a_multi_late: assert property (p_multi_late) else $error("late loss mishandled"); // R14
  property p_hold_empty;
    @(posedge clk_i) disable iff (rst_i)
      load_next && !eod_cmd_reg |=> tx_holding_empty_o;
  endproperty
  a_hold_empty: assert property (p_hold_empty) else $error("empty flag not raised"); // R09
  property p_eod_clear;
    @(posedge clk_i) disable iff (rst_i)
      eod_done && !req_take |=> (req_reg == ifrtx_pkg::REQ_NONE) && !busy_o;
  endproperty
  a_eod_clear: assert property (p_eod_clear) else $error("request kept after EOD"); // R11 R16
  property p_crc_eod;
    @(posedge clk_i) disable iff (rst_i)
      to_crc && !abort |=> crc_phase_reg && (st_reg == ifrtx_pkg::ST_DATA);
  endproperty
  a_crc_eod: assert property (p_crc_eod) else $error("CRC byte not started"); // R08
endmodule : ifrtx_ctrl

`default_nettype wire

// ===== rtl/ifrtx_pkg.sv
// Shared types and constants for the in-frame response transmit control
package ifrtx_pkg;

  localparam int unsigned BYTE_W    = 8;
  localparam logic [2:0]  BIT_LAST  = 3'h7;
  localparam logic [2:0]  BIT_LATE  = 3'h6;
  localparam logic [2:0]  EXTRA_END = 3'h1;
  localparam logic [2:0]  CNT_ZERO  = 3'h0;
  localparam logic [7:0]  CRC_POLY  = 8'h1d;
  localparam logic [7:0]  CRC_INIT  = 8'hff;
  localparam int unsigned REQ_SGL   = 2;
  localparam int unsigned REQ_CRC   = 1;
  localparam int unsigned REQ_NOC   = 0;
  localparam logic [2:0]  REQ_NONE  = 3'h0;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_WAIT  = 7'h02,
    ST_NB    = 7'h04,
    ST_DATA  = 7'h08,
    ST_EXTRA = 7'h10,
    ST_EOD   = 7'h20,
    ST_RETRY = 7'h40
  } ifrtx_state_t;

  typedef enum logic [1:0] {
    SYM_NONE = 2'h0,
    SYM_BIT  = 2'h1,
    SYM_NB   = 2'h2,
    SYM_EOD  = 2'h3
  } ifrtx_kind_t;

  // One symbol handed to the bit encoder: kind plus the logic value
  typedef struct packed {
    ifrtx_kind_t kind;
    logic        value;
  } ifrtx_sym_t;

endpackage : ifrtx_pkg

// ===== tb/ifrtx_bus_model.sv
// Far-side model: finishes symbols and reports arbitration loss
`timescale 1ns/1ps
`default_nettype none
module ifrtx_bus_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       eof_i,
  input  wire logic       sym_valid_i,
  input  wire logic       slow_i,
  input  wire logic [7:0] lose_at_i,
  output logic            sym_done_o,
  output logic            arb_lost_o
);
  logic [1:0] wait_reg;
  logic [7:0] cnt_reg;
  // Symbols are counted per frame, so a retry never loses at the same index
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sym_done_o <= 1'b0;
      arb_lost_o <= 1'b0;
      wait_reg   <= 2'h0;
      cnt_reg    <= 8'h00;
    end else begin
      sym_done_o <= 1'b0;
      arb_lost_o <= 1'b0;
      if (eof_i) begin
        cnt_reg <= 8'h00;
      end else if (sym_valid_i && !sym_done_o) begin
        if (wait_reg == {slow_i, slow_i}) begin
          wait_reg   <= 2'h0;
          sym_done_o <= 1'b1;
          arb_lost_o <= (cnt_reg == lose_at_i);
          cnt_reg    <= cnt_reg + 8'h01;
        end else begin
          wait_reg <= wait_reg + 2'h1;
        end
      end else if (!sym_valid_i) begin
        // A withdrawn symbol must not leave a half-counted stall behind
        wait_reg <= 2'h0;
      end
    end
  end
endmodule : ifrtx_bus_model
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the in-frame response transmit control
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {
    logic [2:0]  req;
    logic        fmt;
    logic        slow;
    logic [1:0]  n;
    logic [23:0] b;
  } ifrtx_row_t;
  localparam logic [5:0] W_REQ = 6'h20, W_EOD = 6'h10, RX_EOD = 6'h08;
  localparam logic [5:0] RX_EOF = 6'h04, RX_BYTE = 6'h02, BUS_ERR = 6'h01;
  logic                  clk = 1'b0, rst = 1'b1, slow = 1'b0, fmt = 1'b0, dvalid = 1'b0;
  logic                  req_wr = 1'b0, eod_wr = 1'b0, eod_rx = 1'b0, eof_rx = 1'b0;
  logic                  rx_byte = 1'b0, bus_err = 1'b0, ce = 1'b1;
  logic [2:0]            req = 3'h0;
  logic [7:0]            data = 8'h00, lose_at = 8'hff;
  logic [2:0]            req_q;
  logic                  eod_q, dready, hempty, sym_valid, sym_done, arb_in, arb_out, unr, busy;
  ifrtx_pkg::ifrtx_sym_t sym;
  logic [2:0]            log_q[$], exp_q[$];
  logic [2:0]            lreq[3] = '{3'h4, 3'h2, 3'h1};
  int                    lidx[3] = '{8, 7, 3};
  int                    errors = 0, cmp_count = 0, t;
  ifrtx_row_t            rows[9] = '{
    '{3'h4, 1'b0, 1'b0, 2'h1, 24'ha50000}, '{3'h4, 1'b1, 1'b1, 2'h1, 24'h3c0000},
    '{3'h2, 1'b0, 1'b0, 2'h3, 24'h0180ff}, '{3'h2, 1'b1, 1'b1, 2'h2, 24'h5a7e00},
    '{3'h1, 1'b0, 1'b1, 2'h2, 24'hc3e100}, '{3'h1, 1'b1, 1'b0, 2'h3, 24'h112233},
    '{3'h3, 1'b0, 1'b0, 2'h2, 24'hf00f00}, '{3'h7, 1'b1, 1'b1, 2'h1, 24'h960000},
    '{3'h5, 1'b0, 1'b0, 2'h1, 24'h690000}};

  ifrtx_ctrl #(.FIFO_DEPTH(8)) dut (
    .clk_i(clk), .rst_i(rst), .ce_i(ce), .req_wr_i(req_wr), .req_bits_i(req),
    .req_bits_o(req_q), .eod_cmd_wr_i(eod_wr), .end_of_data_command_o(eod_q),
    .norm_bit_format_sel_i(fmt), .data_valid_i(dvalid), .data_i(data), .data_ready_o(dready),
    .tx_holding_empty_o(hempty), .eod_rx_i(eod_rx), .eof_rx_i(eof_rx), .rx_byte_i(rx_byte),
    .bus_error_i(bus_err), .sym_o(sym), .sym_valid_o(sym_valid), .sym_done_i(sym_done),
    .arb_lost_i(arb_in), .arb_lost_o(arb_out), .underrun_o(unr), .busy_o(busy));
  ifrtx_bus_model bus (
    .clk_i(clk), .rst_i(rst), .eof_i(eof_rx), .sym_valid_i(sym_valid), .slow_i(slow),
    .lose_at_i(lose_at), .sym_done_o(sym_done), .arb_lost_o(arb_in));

  always #20 clk = ~clk;
  // The symbol still stands in the cycle its done pulse is seen
  always @(posedge clk) if (sym_done === 1'b1) log_q.push_back(sym);

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic summarize();
    if (errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  task automatic strobe(input logic [5:0] m);
    @(posedge clk);
    {req_wr, eod_wr, eod_rx, eof_rx, rx_byte, bus_err} <= m;
    @(posedge clk);
    {req_wr, eod_wr, eod_rx, eof_rx, rx_byte, bus_err} <= 6'h00;
  endtask : strobe

  task automatic push(input logic [63:0] b, input int n);
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      dvalid <= 1'b1;
      data   <= b[63-8*i -: 8];
      @(posedge clk);
      while (dready !== 1'b1) @(posedge clk);
    end
    dvalid <= 1'b0;
  endtask : push

  task automatic exp_byte(input logic [7:0] b, input int k);
    for (int i = 7; i > 7 - k; i--) exp_q.push_back({ifrtx_pkg::SYM_BIT, b[i]});
  endtask : exp_byte

  function automatic logic [7:0] crc8(input logic [63:0] b, input int n);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 0; i < n; i++) begin
      c = c ^ b[63-8*i -: 8];
      for (int k = 0; k < 8; k++) c = c[7] ? {c[6:0], 1'b0} ^ 8'h1d : {c[6:0], 1'b0};
    end
    return ~c;
  endfunction : crc8

  task automatic wait_idle();
    t = 0;
    while ((busy !== 1'b0 || sym_valid !== 1'b0) && t < 3000) begin
      @(negedge clk);
      t++;
    end
  endtask : wait_idle

  // The value carried by an end-of-data symbol is left open, so only its kind is compared
  task automatic finish_tx();
    logic [2:0] g;
    wait_idle();
    check(8'(log_q.size()), 8'(exp_q.size()));
    foreach (exp_q[i]) begin
      g = log_q[i];
      if (g[2:1] == 2'h3) g[0] = 1'b0;
      check(8'(g), 8'(exp_q[i]));
    end
    strobe(RX_EOF);
    log_q.delete();
    exp_q.delete();
  endtask : finish_tx

  task automatic run(input ifrtx_row_t r);
    logic crc, sgl;
    sgl = r.req[2];
    crc = !sgl && r.req[1];
    fmt  <= r.fmt;
    slow <= r.slow;
    push({r.b, 40'h0}, r.n);
    req <= r.req;
    strobe(W_REQ);
    @(negedge clk);
    check(8'(req_q), 8'(r.req));
    strobe(RX_EOD);
    if (!sgl) strobe(W_EOD);
    exp_q.push_back({ifrtx_pkg::SYM_NB, crc ^ r.fmt});
    for (int i = 0; i < r.n; i++) exp_byte(r.b[23-8*i -: 8], 8);
    if (crc) exp_byte(crc8({r.b, 40'h0}, r.n), 8);
    if (!sgl) exp_q.push_back({ifrtx_pkg::SYM_EOD, 1'b0});
    finish_tx();
    check(8'({req_q, eod_q}), 8'h00);
  endtask : run

  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    check({req_q, busy, dready, hempty, sym_valid, arb_out}, 8'h08);
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) run(rows[i]);
    // Requests after a received end of data stay refused until the frame ends
    strobe(RX_EOD);
    for (int i = 0; i < 3; i++) begin
      req <= 3'h1 << i;
      strobe(W_REQ);
      repeat (2) @(negedge clk);
      check(8'({busy, sym_valid, req_q}), 8'h00);
    end
    strobe(RX_EOF);
    // A frozen block must not take a request write
    ce  <= 1'b0;
    req <= 3'h2;
    strobe(W_REQ);
    @(negedge clk);
    check(8'({busy, req_q}), 8'h00);
    @(posedge clk);
    ce <= 1'b1;
    fmt <= 1'b0;
    push(64'hb4 << 56, 1);
    req <= 3'h2;
    strobe(W_REQ);
    strobe(RX_EOD);
    for (t = 0; hempty !== 1'b1 && t < 200; t++) @(negedge clk);
    check(8'(hempty), 8'h01);
    strobe(W_EOD);
    @(negedge clk);
    check(8'(hempty), 8'h00);
    exp_q.push_back({ifrtx_pkg::SYM_NB, 1'b1});
    exp_byte(8'hb4, 8);
    exp_byte(crc8(64'hb4 << 56, 1), 8);
    exp_q.push_back({ifrtx_pkg::SYM_EOD, 1'b0});
    finish_tx();
    check(8'(hempty), 8'h00);
    // Host answers the first empty flag with one byte and the second with the end of data command
    push(64'h11 << 56, 1);
    req <= 3'h1;
    strobe(W_REQ);
    strobe(RX_EOD);
    for (t = 0; hempty !== 1'b1 && t < 200; t++) @(negedge clk);
    push(64'h22 << 56, 1);
    @(negedge clk);
    check(8'(hempty), 8'h00);
    for (t = 0; hempty !== 1'b1 && t < 200; t++) @(negedge clk);
    check(8'(hempty), 8'h01);
    strobe(W_EOD);
    exp_q.push_back({ifrtx_pkg::SYM_NB, 1'b0});
    exp_byte(8'h11, 8);
    exp_byte(8'h22, 8);
    exp_q.push_back({ifrtx_pkg::SYM_EOD, 1'b0});
    finish_tx();
    check(8'({req_q, eod_q, hempty}), 8'h00);
    for (int m = 1; m < 3; m++) begin
      push(64'h5a << 56, 1);
      req <= 3'(m);
      strobe(W_REQ);
      strobe(RX_EOD);
      exp_q.push_back({ifrtx_pkg::SYM_NB, m[1]});
      exp_byte(8'h5a, 8);
      exp_byte(8'hff, 2);
      finish_tx();
      check(8'({unr, req_q}), 8'h08);
    end
    for (int c = 0; c < 3; c++) begin
      push(64'he7 << 56, 1);
      req     <= lreq[c];
      lose_at <= 8'(lidx[c]);
      strobe(W_REQ);
      strobe(RX_EOD);
      for (t = 0; !(sym_done === 1'b1 && arb_in === 1'b1) && t < 200; t++) @(posedge clk);
      strobe(RX_BYTE);
      exp_q.push_back({ifrtx_pkg::SYM_NB, lreq[c][1]});
      exp_byte(8'he7, lidx[c]);
      if (c == 0) exp_byte(8'he7, 8);
      if (c == 1) exp_byte(8'hff, 2);
      finish_tx();
      check(8'({arb_out, req_q}), 8'({c != 0, 3'h0}));
      lose_at <= 8'hff;
    end
    // Fill the buffer until it refuses, then drain it with a stalling far side
    push(64'h0123456789abcdef, 8);
    @(negedge clk);
    check(8'(dready), 8'h00);
    req  <= 3'h1;
    slow <= 1'b1;
    strobe(W_REQ);
    strobe(RX_EOD);
    strobe(W_EOD);
    exp_q.push_back({ifrtx_pkg::SYM_NB, 1'b0});
    for (int i = 0; i < 8; i++) exp_byte(8'(64'h0123456789abcdef >> (56 - 8 * i)), 8);
    exp_q.push_back({ifrtx_pkg::SYM_EOD, 1'b0});
    finish_tx();
    check(8'(dready), 8'h01);
    push(64'h3c << 56, 1);
    req <= 3'h4;
    strobe(W_REQ);
    strobe(RX_EOD);
    strobe(W_EOD);
    wait_idle();
    check(8'({req_q, eod_q}), 8'h00);
    strobe(RX_EOF);
    push(64'h8182 << 48, 2);
    req <= 3'h2;
    strobe(W_REQ);
    strobe(RX_EOD);
    repeat (6) @(posedge clk);
    strobe(BUS_ERR);
    wait_idle();
    check(8'({busy, req_q}), 8'h00);
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    summarize();
  end
endmodule : tb
`default_nettype wire
